// ===== core/flash_host_ctrl.sv
// Host controller that drives a serial flash over its clock, select, data and reset pins.
module flash_host_ctrl #(
  parameter int unsigned HALF_DIV  = flash_host_pkg::HALF_DIV_DEF,
  parameter int unsigned DESEL_CYC = flash_host_pkg::DESEL_CYC_DEF
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst,
  input  wire logic [7:0]            i_addr,
  input  wire logic [31:0]           i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [31:0]           o_rdata,
  input  wire logic [3:0]            i_dq,
  output flash_host_pkg::pins_t      o_pins,
  output logic                       o_busy
);

  // ****************************************************************
  // Types, functions and state
  // ****************************************************************
  typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_SHIFT, ST_DESEL, ST_WAIT, ST_HWRST} state_t;
  typedef enum logic [1:0] {FR_WREN, FR_MAIN, FR_RST1, FR_RST2} frame_t;
  typedef enum logic [1:0] {SEG_OPC, SEG_ADR, SEG_DUM, SEG_DAT} seg_t;

  // Lines used by a lane code.
  function automatic logic [3:0] lane_mask(input logic [1:0] code);
    case (code)
      2'd0:    lane_mask = 4'h1;
      2'd1:    lane_mask = 4'h3;
      default: lane_mask = 4'hf;
    endcase
  endfunction

  // Clock count of a segment.
  function automatic logic [7:0] seg_clocks(input seg_t s, input flash_host_pkg::xfer_cfg_t c);
    case (s)
      SEG_OPC: seg_clocks = 8'h08;
      SEG_ADR: seg_clocks = 8'h18 >> (c.addr_io ? c.lanes : 2'd0);
      SEG_DUM: seg_clocks = c.dummy;
      default: seg_clocks = {2'b00, c.nbytes, 3'b000} >> c.lanes;
    endcase
  endfunction

  // Next present segment; bit 2 marks that one exists.
  function automatic logic [2:0] seg_next(input seg_t s, input flash_host_pkg::xfer_cfg_t c, input frame_t k);
    logic adr;
    logic dum;
    logic dat;
    adr = c.has_addr;
    dum = (c.dummy != 8'h00);
    dat = (c.nbytes != 3'h0);
    seg_next = 3'h0;
    if (k == FR_MAIN) begin
      if (s == SEG_OPC && adr) begin
        seg_next = {1'b1, SEG_ADR};
      end else if (s != SEG_DUM && s != SEG_DAT && dum) begin
        seg_next = {1'b1, SEG_DUM};
      end else if (s != SEG_DAT && dat) begin
        seg_next = {1'b1, SEG_DAT};
      end
    end
  endfunction

  // Opcode of a frame.
  function automatic logic [7:0] frame_opc(input frame_t k, input logic [7:0] opc);
    case (k)
      FR_WREN: frame_opc = flash_host_pkg::OPC_WREN;
      FR_RST1: frame_opc = flash_host_pkg::OPC_RST_EN;
      FR_RST2: frame_opc = flash_host_pkg::OPC_RST;
      default: frame_opc = opc;
    endcase
  endfunction

  flash_host_pkg::xfer_cfg_t ctrl_r;
  flash_host_pkg::xfer_cfg_t wcfg;
  flash_host_pkg::pins_t     pins_r;
  logic [7:0]                opc_r;
  logic [23:0]               addr_r;
  logic [31:0]               wdata_r;
  logic [31:0]               rx_r;
  logic [31:0]               tx_r;
  logic [31:0]               rdata_r;
  logic [7:0]                div_r;
  logic [7:0]                clk_left_r;
  logic [15:0]               wait_r;
  logic [7:0]                last_opc_r;
  logic                      hi_r;
  logic                      paused_r;
  logic                      pause_req_r;
  logic                      refused_r;
  state_t                    st_r;
  frame_t                    kind_r;
  seg_t                      seg_r;
  logic [3:0]                dq_s;
  logic [1:0]                code;
  logic [2:0]                nx;
  logic                      start_p;
  logic                      swrst_p;
  logic                      hwrst_p;
  logic                      half_end;
  logic                      drive;
  logic                      quad_bad;
  logic [3:0]                lmask;

  assign wcfg     = flash_host_pkg::xfer_cfg_t'(i_wdata);
  assign start_p  = i_wr && i_addr == flash_host_pkg::REG_CTRL && wcfg.start;
  assign swrst_p  = i_wr && i_addr == flash_host_pkg::REG_CMD && i_wdata[flash_host_pkg::CMD_SWRST];
  assign hwrst_p  = i_wr && i_addr == flash_host_pkg::REG_CMD && i_wdata[flash_host_pkg::CMD_HWRST];
  assign quad_bad = wcfg.lanes[1] && !wcfg.qe;
  assign code     = (seg_r == SEG_OPC || (seg_r == SEG_ADR && !ctrl_r.addr_io)) ? 2'd0 : ctrl_r.lanes;
  assign nx       = seg_next(seg_r, ctrl_r, kind_r);
  assign half_end = (div_r == 8'(HALF_DIV - 1));
  assign drive    = (seg_r != SEG_DUM) && !(seg_r == SEG_DAT && ctrl_r.rd);
  assign lmask    = lane_mask(code);

  pin_sync #(
    .W (4)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_d       (i_dq),
    .o_q       (dq_s)
  );

  // ****************************************************************
  // Register file
  // ****************************************************************
  // Configuration is only taken while idle so a running frame stays stable.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r      <= flash_host_pkg::CTRL_RST;
      opc_r       <= 8'h00;
      addr_r      <= 24'h00_0000;
      wdata_r     <= 32'h0000_0000;
      pause_req_r <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == flash_host_pkg::REG_CTRL && st_r == ST_IDLE) begin
        ctrl_r <= wcfg;
      end
      if (i_addr == flash_host_pkg::REG_OPC && st_r == ST_IDLE) begin
        opc_r <= i_wdata[7:0];
      end
      if (i_addr == flash_host_pkg::REG_ADDR && st_r == ST_IDLE) begin
        addr_r <= i_wdata[23:0];
      end
      if (i_addr == flash_host_pkg::REG_WDATA && st_r == ST_IDLE) begin
        wdata_r <= i_wdata;
      end
      if (i_addr == flash_host_pkg::REG_CMD) begin
        pause_req_r <= i_wdata[flash_host_pkg::CMD_PAUSE];
      end
    end
  end

  // Refusal flag: set wins over a write-one clear.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      refused_r <= 1'b0;
    end else if (start_p && (st_r != ST_IDLE || quad_bad)) begin
      refused_r <= 1'b1;
    end else if (i_wr && i_addr == flash_host_pkg::REG_STATUS && i_wdata[flash_host_pkg::STAT_REFUSED]) begin
      refused_r <= 1'b0;
    end
  end

  // Read data stand for the single cycle after the read strobe.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (!i_rd) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      unique case (i_addr)
        flash_host_pkg::REG_CTRL:   rdata_r <= {ctrl_r[31:1], 1'b0};
        flash_host_pkg::REG_OPC:    rdata_r <= {24'h00_0000, opc_r};
        flash_host_pkg::REG_ADDR:   rdata_r <= {8'h00, addr_r};
        flash_host_pkg::REG_WDATA:  rdata_r <= wdata_r;
        flash_host_pkg::REG_RDATA:  rdata_r <= rx_r;
        flash_host_pkg::REG_CMD:    rdata_r <= {31'h0000_0000, pause_req_r};
        flash_host_pkg::REG_STATUS: rdata_r <= {28'h000_0000, st_r == ST_WAIT || st_r == ST_HWRST,
                                                refused_r, paused_r, st_r != ST_IDLE};
        default:                    rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Frame engine
  // ****************************************************************
  // Each bit is a low half then a high half; data moves at the falling edge
  // that closes the high half and is sampled at the rising edge.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_r       <= ST_IDLE;
      kind_r     <= FR_MAIN;
      seg_r      <= SEG_OPC;
      div_r      <= 8'h00;
      hi_r       <= 1'b0;
      paused_r   <= 1'b0;
      clk_left_r <= 8'h00;
      wait_r     <= 16'h0000;
      tx_r       <= 32'h0000_0000;
      rx_r       <= 32'h0000_0000;
      last_opc_r <= 8'h00;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          div_r <= 8'h00;
          if (hwrst_p) begin
            st_r   <= ST_HWRST;
            wait_r <= flash_host_pkg::RESET_PULSE_MIN_CYC;
          end else if (swrst_p) begin
            st_r   <= ST_SEL;
            kind_r <= FR_RST1;
            tx_r   <= {flash_host_pkg::OPC_RST_EN, 24'h00_0000};
          end else if (start_p && !quad_bad) begin
            st_r   <= ST_SEL;
            kind_r <= wcfg.auto_wren ? FR_WREN : FR_MAIN;
            tx_r   <= {frame_opc(wcfg.auto_wren ? FR_WREN : FR_MAIN, opc_r), 24'h00_0000};
            rx_r   <= 32'h0000_0000;
          end
          seg_r      <= SEG_OPC;
          clk_left_r <= 8'h08;
        end
        ST_SEL: begin
          div_r <= half_end ? 8'h00 : div_r + 8'h01;
          hi_r  <= 1'b0;
          if (half_end) begin
            st_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (paused_r) begin
            paused_r <= pause_req_r;
          end else if (pause_req_r && !ctrl_r.qe && !hi_r) begin
            paused_r <= 1'b1;
          end else begin
            div_r <= half_end ? 8'h00 : div_r + 8'h01;
            if (half_end) begin
              hi_r <= !hi_r;
            end
            if (half_end && !hi_r && seg_r == SEG_DAT && ctrl_r.rd) begin
              case (code)
                2'd0:    rx_r <= {rx_r[30:0], dq_s[1]};
                2'd1:    rx_r <= {rx_r[29:0], dq_s[1:0]};
                default: rx_r <= {rx_r[27:0], dq_s};
              endcase
            end
            if (half_end && hi_r) begin
              if (clk_left_r > 8'h01) begin
                clk_left_r <= clk_left_r - 8'h01;
                case (code)
                  2'd0:    tx_r <= tx_r << 1;
                  2'd1:    tx_r <= tx_r << 2;
                  default: tx_r <= tx_r << 4;
                endcase
              end else if (nx[2]) begin
                seg_r      <= seg_t'(nx[1:0]);
                clk_left_r <= seg_clocks(seg_t'(nx[1:0]), ctrl_r);
                case (seg_t'(nx[1:0]))
                  SEG_ADR: tx_r <= {addr_r, 8'h00};
                  SEG_DAT: tx_r <= wdata_r;
                  default: tx_r <= 32'h0000_0000;
                endcase
              end else begin
                st_r       <= ST_DESEL;
                div_r      <= 8'h00;
                last_opc_r <= frame_opc(kind_r, opc_r);
              end
            end
          end
        end
        ST_DESEL: begin
          div_r <= div_r + 8'h01;
          if (div_r == 8'(DESEL_CYC - 1)) begin
            div_r      <= 8'h00;
            seg_r      <= SEG_OPC;
            clk_left_r <= 8'h08;
            unique case (kind_r)
              FR_WREN: begin
                st_r   <= ST_SEL;
                kind_r <= FR_MAIN;
                tx_r   <= {opc_r, 24'h00_0000};
              end
              FR_RST1: begin
                st_r   <= ST_SEL;
                kind_r <= FR_RST2;
                tx_r   <= {flash_host_pkg::OPC_RST, 24'h00_0000};
              end
              FR_RST2: begin
                st_r   <= ST_WAIT;
                wait_r <= flash_host_pkg::SW_RESET_CYC;
              end
              FR_MAIN: st_r <= ST_IDLE;
            endcase
          end
        end
        ST_WAIT, ST_HWRST: begin
          wait_r <= wait_r - 16'h0001;
          if (wait_r == 16'h0001) begin
            st_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Line 2 carries the write-protect level and line 3 the pause level
  // unless quad mode has taken them over as data lines.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pins_r <= '{sclk: 1'b0, cs_n: 1'b1, rst_n: 1'b1, dq_o: 4'h0, dq_oe_n: 4'hf};
    end else begin
      // Select falls only once the clock already stands at its idle level.
      pins_r.cs_n  <= !((st_r == ST_SEL && pins_r.sclk == ctrl_r.cpol) || st_r == ST_SHIFT);
      pins_r.sclk  <= (st_r == ST_SHIFT) ? hi_r : ctrl_r.cpol;
      pins_r.rst_n <= (st_r != ST_HWRST);
      if ((st_r == ST_SEL || st_r == ST_SHIFT) && drive) begin
        case (code)
          2'd0:    pins_r.dq_o[1:0] <= {1'b0, tx_r[31]};
          2'd1:    pins_r.dq_o[1:0] <= tx_r[31:30];
          default: pins_r.dq_o[1:0] <= tx_r[29:28];
        endcase
        pins_r.dq_oe_n[1:0] <= ~lmask[1:0];
      end else begin
        pins_r.dq_o[1:0]    <= 2'b00;
        pins_r.dq_oe_n[1:0] <= 2'b11;
      end
      if (code == 2'd2 && (st_r == ST_SEL || st_r == ST_SHIFT)) begin
        pins_r.dq_o[3:2]    <= tx_r[31:30];
        pins_r.dq_oe_n[3:2] <= drive ? 2'b00 : 2'b11;
      end else if (!ctrl_r.qe) begin
        pins_r.dq_o[3:2]    <= {!paused_r, ctrl_r.wp_lvl};
        pins_r.dq_oe_n[3:2] <= 2'b00;
      end else begin
        pins_r.dq_o[3:2]    <= 2'b00;
        pins_r.dq_oe_n[3:2] <= 2'b11;
      end
    end
  end

  assign o_pins  = pins_r;
  assign o_rdata = rdata_r;

  // Busy flag toward software.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (st_r != ST_IDLE);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  logic [15:0] rst_low_cnt;

  // Counts how long the reset pin has been low.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rst_low_cnt <= 16'h0000;
    end else begin
      rst_low_cnt <= pins_r.rst_n ? 16'h0000 : rst_low_cnt + 16'h0001;
    end
  end

  sequence s_frame_open;
    $fell(pins_r.cs_n);
  endsequence

  sequence s_pause_pin_low;
    $fell(pins_r.dq_o[3]) && !pins_r.dq_oe_n[3] && !ctrl_r.qe;
  endsequence

  AST_MODE_IDLE: assert property (s_frame_open |-> pins_r.sclk == ctrl_r.cpol
                                  && $past(pins_r.sclk) == ctrl_r.cpol)
    else $error("Clock not at idle level when select fell.");
  AST_TX_ON_FALL: assert property ($changed(pins_r.dq_o[0]) && !pins_r.dq_oe_n[0] && !pins_r.cs_n
                                   && !$fell(pins_r.cs_n) |-> !pins_r.sclk)
    else $error("Data line 0 changed while clock high.");
  AST_RX_ON_RISE: assert property ($changed(rx_r) && st_r == ST_SHIFT |=> $rose(pins_r.sclk))
    else $error("Read data sampled away from a rising edge.");
  AST_QUAD_REFUSE: assert property (start_p && st_r == ST_IDLE && quad_bad
                                    |=> refused_r && st_r == ST_IDLE)
    else $error("Quad transfer started without quad enable.");
  AST_PAUSE_ENTRY: assert property (s_pause_pin_low |-> !pins_r.sclk && !pins_r.cs_n)
    else $error("Pause asserted with clock high or deselected.");
  AST_PAUSE_HOLD_CS: assert property (paused_r |=> !pins_r.cs_n)
    else $error("Select released during pause.");
  AST_HWRST_WIDTH: assert property ($rose(pins_r.rst_n) |-> rst_low_cnt >= flash_host_pkg::RESET_PULSE_MIN_CYC)
    else $error("Reset pulse shorter than minimum.");
  AST_SWRST_ORDER: assert property (s_frame_open and kind_r == FR_RST2
                                    |-> last_opc_r == flash_host_pkg::OPC_RST_EN)
    else $error("Reset opcode not preceded by reset enable.");
  AST_SWRST_QUIET: assert property (st_r == ST_WAIT |=> pins_r.cs_n)
    else $error("Frame opened during reset wait.");
  AST_WREN_FIRST: assert property (s_frame_open and kind_r == FR_MAIN and ctrl_r.auto_wren
                                   |-> last_opc_r == flash_host_pkg::OPC_WREN)
    else $error("Main frame without preceding write enable.");

endmodule // flash_host_ctrl

// ===== core/flash_host_pkg.sv
// Constants, register map and carrier types of the serial flash host controller.
package flash_host_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned SYS_CLK_MHZ         = 50;
  localparam int unsigned HALF_DIV_DEF        = 4;
  localparam int unsigned DESEL_CYC_DEF       = 8;
  localparam int unsigned RESET_PULSE_MIN_NS  = 1000;
  localparam int unsigned SW_RESET_US         = 30;
  localparam logic [15:0] RESET_PULSE_MIN_CYC = 16'((RESET_PULSE_MIN_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [15:0] SW_RESET_CYC        = 16'(SW_RESET_US * SYS_CLK_MHZ);

  // ****************************************************************
  // Register offsets and fields
  // ****************************************************************
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_OPC      = 8'h04;
  localparam logic [7:0]  REG_ADDR     = 8'h08;
  localparam logic [7:0]  REG_WDATA    = 8'h0c;
  localparam logic [7:0]  REG_RDATA    = 8'h10;
  localparam logic [7:0]  REG_CMD      = 8'h14;
  localparam logic [7:0]  REG_STATUS   = 8'h18;
  localparam int unsigned CMD_PAUSE    = 0;
  localparam int unsigned CMD_HWRST    = 1;
  localparam int unsigned CMD_SWRST    = 2;
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_PAUSED  = 1;
  localparam int unsigned STAT_REFUSED = 2;
  localparam int unsigned STAT_RSTWAIT = 3;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0200;

  // ****************************************************************
  // Opcodes sent by the controller itself, plus OPC_UNLOCK, which it never sends
  // ****************************************************************
  localparam logic [7:0] OPC_WREN   = 8'h06;
  localparam logic [7:0] OPC_RST_EN = 8'h66;
  localparam logic [7:0] OPC_RST    = 8'h99;
  localparam logic [7:0] OPC_UNLOCK = 8'h39;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  // Control word; lanes 0 is one line, 1 is two lines, 2 is four lines.
  typedef struct packed {
    logic [2:0] nbytes;
    logic [4:0] rsv_hi;
    logic [7:0] dummy;
    logic [5:0] rsv_lo;
    logic       wp_lvl;
    logic       has_addr;
    logic       addr_io;
    logic       qe;
    logic       auto_wren;
    logic       rd;
    logic [1:0] lanes;
    logic       cpol;
    logic       start;
  } xfer_cfg_t;

  // Pin drive towards the flash; an enable is low while the line is driven.
  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic       rst_n;
    logic [3:0] dq_o;
    logic [3:0] dq_oe_n;
  } pins_t;

endpackage

// ===== core/pin_sync.sv
// Two-stage synchroniser for the data lines coming back from the flash.
module pin_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= '0;
      o_q    <= '0;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end

endmodule // pin_sync

// ===== dv/flash_dev_model.sv
// Behavioural serial flash device model facing the host controller.
module flash_dev_model (
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic       i_rst_n,
  input  wire logic [3:0] i_dq,
  output logic      [3:0] o_dq,
  output logic      [3:0] o_en,
  output logic      [7:0] o_opc,
  output logic      [7:0] o_prev,
  output logic            o_mode_err,
  output int              o_rst_ns
);
  timeunit 1ns;
  timeprecision 1ps;
  int          nbit;
  logic [7:0]  sh;
  logic [7:0]  resp;
  logic        idle_clk;
  realtime     t0;
  localparam logic [7:0] DUAL_OPC = 8'h3b;
  localparam logic [7:0] QUAD_OPC = 8'h6b;

  // Power-on state: nothing driven, no instruction seen.
  initial begin
    nbit = 0;
    o_dq = 4'h0;
    o_en = 4'h0;
    o_opc = 8'h00;
    o_prev = 8'h00;
    o_mode_err = 1'b0;
    o_rst_ns = 0;
  end

  // Select starts an instruction; the clock level here fixes the mode.
  always @(negedge i_cs_n) begin
    nbit = 0;
    idle_clk = i_sclk;
  end

  // Deselect ends it; the clock must idle at the same level, and lines are let go.
  always @(posedge i_cs_n) begin
    if (i_sclk !== idle_clk) o_mode_err = 1'b1;
    o_en = 4'h0;
    o_dq = ~o_dq;
  end

  // Opcode bits enter MSB first on rising edges, unless paused or held in reset.
  always @(posedge i_sclk) begin
    if (!i_cs_n && i_rst_n && i_dq[3] && nbit < 8) begin
      sh = {sh[6:0], i_dq[0]};
      nbit++;
      if (nbit == 8) begin
        o_prev = o_opc;
        o_opc = sh;
        resp = ~sh;
      end
    end
  end

  // Reply bits leave on falling edges once the opcode is complete; in quad reads line 3 is data, not pause.
  always @(negedge i_sclk) begin
    if (!i_cs_n && i_rst_n && (i_dq[3] || o_opc == QUAD_OPC) && nbit == 8) begin
      if (o_opc == QUAD_OPC) begin
        o_en = 4'hf;
        o_dq = resp[7:4];
        resp = {resp[3:0], ~resp[7:4]};
      end else if (o_opc == DUAL_OPC) begin
        o_en[1:0] = 2'b11;
        o_dq[1:0] = resp[7:6];
        resp = {resp[5:0], ~resp[7:6]};
      end else begin
        o_en[1] = 1'b1;
        o_dq[1] = resp[7];
        resp = {resp[6:0], ~resp[7]};
      end
    end
  end

  // The reset pin overrides everything and its low time is measured.
  always @(negedge i_rst_n) begin
    t0 = $realtime;
    nbit = 0;
    o_en = 4'h0;
  end
  always @(posedge i_rst_n) o_rst_ns = int'($realtime - t0);
endmodule // flash_dev_model

// ===== dv/test_flash_host_ctrl.sv
// Register-level testbench of the serial flash host controller.
module test_flash_host_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  i_clk_sys;
  logic                  i_rst;
  logic [7:0]            i_addr;
  logic [31:0]           i_wdata;
  logic                  i_wr;
  logic                  i_rd;
  logic [31:0]           o_rdata;
  logic                  o_busy;
  flash_host_pkg::pins_t pins;
  wire  [3:0]            dq;
  logic [3:0]            dev_dq;
  logic [3:0]            dev_en;
  logic [7:0]            opc;
  logic [7:0]            prev;
  logic [7:0]            ox;
  logic                  mode_err;
  logic                  flip;
  logic [31:0]           rv;
  int                    rst_ns;
  int                    error_cnt;
  int                    check_count;
  int                    cyc;
  int                    busy_cyc;

  // Released data lines toggle; write-protect and pause lines have pull-ups.
  assign dq = (~pins.dq_oe_n & pins.dq_o) | (pins.dq_oe_n & dev_en & dev_dq) |
              (pins.dq_oe_n & ~dev_en & {2'b11, flip, flip});

  flash_host_ctrl #(.HALF_DIV(4), .DESEL_CYC(2)) uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_dq(dq), .o_pins(pins), .o_busy(o_busy));

  flash_dev_model dev (.i_sclk(pins.sclk), .i_cs_n(pins.cs_n), .i_rst_n(pins.rst_n), .i_dq(dq), .o_dq(dev_dq),
    .o_en(dev_en), .o_opc(opc), .o_prev(prev), .o_mode_err(mode_err), .o_rst_ns(rst_ns));

  // System clock and the watchdog that cuts a hang short.
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    flip <= ~flip;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read strobe for one cycle; data stand in the cycle after it.
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
    chk(rv, exp);
  endtask

  function automatic logic [31:0] cfg(input logic [2:0] nb, input logic r, input logic [1:0] ln, input logic cp,
                                      input logic aw);
    flash_host_pkg::xfer_cfg_t c;
    c = '0;
    c.nbytes = nb;
    c.rd = r;
    c.lanes = ln;
    c.cpol = cp;
    c.auto_wren = aw;
    c.wp_lvl = 1'b1;
    c.start = 1'b1;
    return c;
  endfunction

  task automatic wait_idle();
    busy_cyc = 0;
    repeat (3) @(posedge i_clk_sys);
    while (o_busy === 1'b1 && busy_cyc < 4000) begin
      @(posedge i_clk_sys);
      busy_cyc++;
    end
    if (busy_cyc >= 4000) begin
      error_cnt++;
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset values, framed reads in both modes, refusals, resets.
  initial begin
    i_rst = 1'b1;
    {i_addr, i_wdata, i_wr, i_rd, flip, error_cnt, check_count, cyc} = '0;
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rchk(8'h00, 32'h0000_0200);
    rchk(8'h18, 32'h0);
    $display("test reset done");
    for (int m = 0; m < 2; m++) begin
      ox = 8'h9e + 8'(m);
      wr(8'h04, {24'h0, ox});
      wr(8'h00, cfg(3'h1, 1'b1, 2'h0, m[0], 1'b0));
      wait_idle();
      chk({24'h0, opc}, {24'h0, ox});
      rchk(8'h10, {24'h0, ~ox});
      chk({31'h0, mode_err}, 32'h0);
    end
    wr(8'h04, 32'h3b);
    wr(8'h00, cfg(3'h1, 1'b1, 2'h1, 1'b0, 1'b0));
    wait_idle();
    rchk(8'h10, 32'hc4);
    wr(8'h04, 32'h6b);
    wr(8'h00, cfg(3'h1, 1'b1, 2'h2, 1'b0, 1'b0) | 32'h40);
    wait_idle();
    rchk(8'h10, 32'h94);
    wr(8'h04, 32'h02);
    wr(8'h00, cfg(3'h0, 1'b0, 2'h0, 1'b0, 1'b1));
    wait_idle();
    chk({16'h0, prev, opc}, {16'h0, flash_host_pkg::OPC_WREN, 8'h02});
    $display("test frames done");
    wr(8'h00, cfg(3'h1, 1'b1, 2'h2, 1'b0, 1'b0));
    rchk(8'h18, 32'h4);
    wr(8'h18, 32'h4);
    rchk(8'h18, 32'h0);
    wr(8'h04, 32'ha5);
    wr(8'h00, cfg(3'h1, 1'b1, 2'h0, 1'b0, 1'b0));
    repeat (20) @(posedge i_clk_sys);
    wr(8'h14, 32'h1);
    repeat (8) @(posedge i_clk_sys);
    chk({31'h0, dq[3]}, 32'h0);
    wr(8'h00, cfg(3'h1, 1'b1, 2'h0, 1'b0, 1'b0));
    rchk(8'h18, 32'h7);
    wr(8'h18, 32'h4);
    wr(8'h14, 32'h0);
    wait_idle();
    chk({24'h0, opc}, 32'ha5);
    rchk(8'h10, 32'h5a);
    $display("test refusal and pause pin done");
    wr(8'h14, 32'h4);
    wait_idle();
    chk({16'h0, prev, opc}, {16'h0, flash_host_pkg::OPC_RST_EN, flash_host_pkg::OPC_RST});
    chk({31'h0, busy_cyc >= 1500}, 32'h1);
    wr(8'h14, 32'h2);
    wait_idle();
    chk({31'h0, rst_ns >= 1000}, 32'h1);
    $display("test resets done");
    report_and_stop();
  end
endmodule // test_flash_host_ctrl
